// file: pkg/gfp_params.svh
// Offsets, field positions, reset values and limits of the frame policy register
`ifndef GFP_PARAMS_SVH
`define GFP_PARAMS_SVH
`define GFP_REG_ADDR       12'h004
`define GFP_BIT_RSVD7      3'd7
`define GFP_BIT_MC_EXCL    3'd6
`define GFP_BIT_RSVD5      3'd5
`define GFP_BIT_FAIR       3'd4
`define GFP_BIT_NO_COLDROP 3'd3
`define GFP_BIT_HUGE       3'd2
`define GFP_BIT_LEGAL_DIS  3'd1
`define GFP_BIT_PRIO_RSV   3'd0
`define GFP_REG_RESET      8'hf0
`define GFP_LEN_HUGE       11'd1916
`define GFP_LEN_LEGAL_DIS  11'd1536
`define GFP_LEN_TAGGED     11'd1522
`define GFP_LEN_UNTAGGED   11'd1518
`define GFP_COLL_LIMIT     5'd16
`define GFP_PRIO_BUFS      6'd48
`define GFP_SYNC_STAGES    2
`endif

// file: pkg/gfp_pkg.sv
// Types shared by the frame policy register block
package gfp_pkg;
  typedef enum {
    GFP_SIZE_NORMAL,
    GFP_SIZE_LEGAL_DIS,
    GFP_SIZE_HUGE
  } gfp_size_mode_type;
  typedef logic [7:0]  gfp_cfg_type;
  typedef logic [10:0] gfp_len_type;
endpackage

// file: rtl/gfp_ctrl.sv
// Frame policy control register with APB slave and registered decisions
`timescale 1ns/1ps
`include "gfp_params.svh"
module gfp_ctrl (
  input  wire logic                 CORE_CLK,
  input  wire logic                 NRST,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic          [11:0] PADDR,
  input  wire logic          [31:0] PWDATA,
  input  wire logic           [3:0] PSTRB,
  output logic               [31:0] PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 COLLISION_POLICY_STRAP_PIN,
  input  wire logic                 MAX_SIZE_STRAP_PIN,
  input  wire logic                 FRM_VALID,
  input  wire gfp_pkg::gfp_len_type FRM_LEN,
  input  wire logic                 FRM_TAGGED,
  input  wire logic                 FRM_SPECIAL_TAG,
  input  wire logic                 FRM_DA_BCAST,
  input  wire logic                 FRM_DA_MCAST,
  input  wire logic           [4:0] FRM_COLLISIONS,
  input  wire logic                 FRM_FC_CONTEND,
  output logic                      RES_VALID,
  output logic                      RES_LEN_OK,
  output logic                      RES_STORM_REGULATE,
  output logic                      RES_COLL_DROP,
  output logic                      RES_DROP_NONFC,
  output logic                      RES_APPLY_FC,
  output logic                [5:0] RESERVED_BUFS
);
  import gfp_pkg::*;

  // ==========================================================
  // Strap capture
  logic [1:0] strap_sync;
  logic       strap_valid;
  logic       loaded_q;

  gfp_strap_sync #(
    .NUM_PINS (2)
  ) u_strap (
    .core_clk   (CORE_CLK),
    .nrst       (NRST),
    .pins       ({MAX_SIZE_STRAP_PIN, COLLISION_POLICY_STRAP_PIN}),
    .pins_sync  (strap_sync),
    .sync_valid (strap_valid)
  );

  logic load_now;
  assign load_now = strap_valid && !loaded_q;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) loaded_q <= 1'b0;
    else       loaded_q <= loaded_q || strap_valid;
  end

  // ==========================================================
  // APB slave
  gfp_cfg_type cfg_q;
  gfp_cfg_type cfg_d;
  logic        setup;
  logic        hit;
  logic        wr_fire;
  logic        pready_d;
  logic [31:0] prdata_d;
  logic        pslverr_d;

  assign setup     = PSEL && !PENABLE;
  assign hit       = (PADDR == `GFP_REG_ADDR);
  // Bus held off until the straps are in, so no write races the load.
  // Answer one cycle after setup once loaded; an access that started
  // early simply waits in its access phase until the load is done.
  assign pready_d  = PSEL && !PREADY && loaded_q;
  assign prdata_d  = (pready_d && hit) ? {24'h000000, cfg_q} : 32'h00000000;
  assign pslverr_d = pready_d && !hit;
  assign wr_fire   = PSEL && PENABLE && PREADY && PWRITE && hit && PSTRB[0];

  always_comb begin
    cfg_d = cfg_q;
    if (load_now) begin
      cfg_d[`GFP_BIT_NO_COLDROP] = strap_sync[0];
      cfg_d[`GFP_BIT_LEGAL_DIS]  = strap_sync[1];
    end else if (wr_fire) begin
      // Reserved bits are stored as written; software keeps them at one
      cfg_d = PWDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q   <= `GFP_REG_RESET;
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      PREADY  <= pready_d;
      PRDATA  <= prdata_d;
      PSLVERR <= pslverr_d;
    end
  end

  // ==========================================================
  // Frame decisions
  logic       len_ok;
  logic       storm_reg;
  logic       coll_drop;
  logic       drop_nonfc;
  logic       apply_fc;
  logic [5:0] rsv_bufs;

  gfp_frame_policy u_policy (
    .cfg             (cfg_q),
    .frm_len         (FRM_LEN),
    .frm_tagged      (FRM_TAGGED),
    .frm_special_tag (FRM_SPECIAL_TAG),
    .frm_da_bcast    (FRM_DA_BCAST),
    .frm_da_mcast    (FRM_DA_MCAST),
    .frm_collisions  (FRM_COLLISIONS),
    .frm_fc_contend  (FRM_FC_CONTEND),
    .len_ok          (len_ok),
    .storm_regulate  (storm_reg),
    .coll_drop       (coll_drop),
    .drop_nonfc      (drop_nonfc),
    .apply_fc        (apply_fc),
    .reserved_bufs   (rsv_bufs)
  );

  // Result flags are zero outside a query so consumers can OR them safely; RESERVED_BUFS is not gated by FRM_VALID
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RES_VALID          <= 1'b0;
      RES_LEN_OK         <= 1'b0;
      RES_STORM_REGULATE <= 1'b0;
      RES_COLL_DROP      <= 1'b0;
      RES_DROP_NONFC     <= 1'b0;
      RES_APPLY_FC       <= 1'b0;
      RESERVED_BUFS      <= 6'd0;
    end else begin
      RES_VALID          <= FRM_VALID;
      RES_LEN_OK         <= FRM_VALID && len_ok;
      RES_STORM_REGULATE <= FRM_VALID && storm_reg;
      RES_COLL_DROP      <= FRM_VALID && coll_drop;
      RES_DROP_NONFC     <= FRM_VALID && drop_nonfc;
      RES_APPLY_FC       <= FRM_VALID && apply_fc;
      RESERVED_BUFS      <= rsv_bufs;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  a_storm_mc_excl: assert property (
    $past(FRM_VALID) && $past(FRM_DA_MCAST) && !$past(FRM_DA_BCAST)
    |-> RES_STORM_REGULATE == !$past(cfg_q[`GFP_BIT_MC_EXCL]))
    else $error("multicast storm regulation wrong");

  a_fair_drop: assert property (
    $past(FRM_VALID) && $past(FRM_FC_CONTEND) && $past(cfg_q[`GFP_BIT_FAIR])
    |-> RES_DROP_NONFC && !RES_APPLY_FC)
    else $error("fair mode did not drop non-flow-controlled source");

  a_unfair_fc: assert property (
    $past(FRM_VALID) && $past(FRM_FC_CONTEND) && !$past(cfg_q[`GFP_BIT_FAIR])
    |-> RES_APPLY_FC && !RES_DROP_NONFC)
    else $error("flow control not applied with fair mode off");

  a_coll_drop: assert property (
    $past(FRM_VALID) |-> RES_COLL_DROP ==
    (($past(FRM_COLLISIONS) >= `GFP_COLL_LIMIT) && !$past(cfg_q[`GFP_BIT_NO_COLDROP])))
    else $error("excessive collision decision wrong");

  a_strap_load: assert property (
    $rose(loaded_q) |-> cfg_q[`GFP_BIT_NO_COLDROP] == $past(strap_sync[0])
    && cfg_q[`GFP_BIT_LEGAL_DIS] == $past(strap_sync[1]))
    else $error("strap level not loaded");

  a_strap_default: assert property (
    !loaded_q |-> !cfg_q[`GFP_BIT_NO_COLDROP] && !PREADY)
    else $error("collision bit not low before strap load");

  a_huge_len: assert property (
    $past(FRM_VALID) && $past(cfg_q[`GFP_BIT_HUGE])
    |-> RES_LEN_OK == ($past(FRM_LEN) <= `GFP_LEN_HUGE))
    else $error("huge frame limit wrong");

  a_legal_len: assert property (
    $past(FRM_VALID) && !$past(cfg_q[`GFP_BIT_HUGE]) && $past(cfg_q[`GFP_BIT_LEGAL_DIS])
    |-> RES_LEN_OK == ($past(FRM_LEN) <= `GFP_LEN_LEGAL_DIS))
    else $error("1536 byte limit wrong");

  a_normal_len: assert property (
    $past(FRM_VALID) && $past(cfg_q[2:1]) == 2'b00
    |-> RES_LEN_OK == ($past(FRM_LEN) <= (($past(FRM_TAGGED) && !$past(FRM_SPECIAL_TAG))
        ? `GFP_LEN_TAGGED : `GFP_LEN_UNTAGGED)))
    else $error("normal frame limit wrong");

  a_prio_bufs: assert property (
    ##1 RESERVED_BUFS == ($past(cfg_q[`GFP_BIT_PRIO_RSV]) ? `GFP_PRIO_BUFS : 6'd0))
    else $error("reserved buffer count wrong");

  a_apb_answer: assert property (
    PSEL && !PENABLE && loaded_q |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle after setup");

  // Results are registered, so frame checks look one cycle back
  a_storm_bcast: assert property (
    $past(FRM_VALID) && $past(FRM_DA_BCAST) |-> RES_STORM_REGULATE)
    else $error("broadcast frame not storm regulated");

  a_fc_exclusive: assert property (
    !(RES_DROP_NONFC && RES_APPLY_FC))
    else $error("fair drop and flow control both given");

  a_coll_keep: assert property (
    $past(FRM_VALID) && $past(cfg_q[`GFP_BIT_NO_COLDROP]) |-> !RES_COLL_DROP)
    else $error("frame dropped although no-drop bit set");

  a_special_tag: assert property (
    $past(FRM_VALID) && $past(cfg_q[2:1]) == 2'b00 && $past(FRM_TAGGED)
    && $past(FRM_SPECIAL_TAG)
    |-> RES_LEN_OK == ($past(FRM_LEN) <= `GFP_LEN_UNTAGGED))
    else $error("special-tagged frame given the tagged limit");

  a_rsv_none: assert property (
    !$past(cfg_q[`GFP_BIT_PRIO_RSV]) |-> RESERVED_BUFS == 6'd0)
    else $error("buffers reserved with reserve bit clear");

  a_res_follow: assert property (
    RES_VALID == $past(FRM_VALID))
    else $error("result strobe not one cycle after query");

  a_res_idle: assert property (
    !RES_VALID |-> !RES_LEN_OK && !RES_STORM_REGULATE && !RES_COLL_DROP
    && !RES_DROP_NONFC && !RES_APPLY_FC)
    else $error("result bits high outside a result cycle");

  a_loaded_once: assert property (
    loaded_q |=> loaded_q && !load_now)
    else $error("strap load repeated");

  // ==========================================================
  // Bus assertions
  a_apb_wait: assert property (
    PSEL && PENABLE && !PREADY && loaded_q |=> PREADY)
    else $error("waiting access not answered once loaded");

  a_pready_pulse: assert property (
    PREADY |=> !PREADY)
    else $error("pready held for more than one cycle");

  a_apb_rdata: assert property (
    setup && loaded_q && !PWRITE && hit |=> PRDATA == {24'h000000, $past(cfg_q)})
    else $error("read data not the register value");

  a_apb_err: assert property (
    setup && loaded_q && !hit |=> PSLVERR && PRDATA == 32'h00000000)
    else $error("bad address not refused");

  a_prdata_idle: assert property (
    !PREADY |-> PRDATA == 32'h00000000 && !PSLVERR)
    else $error("bus answer lines high outside an answer");

  a_wr_lands: assert property (
    wr_fire |=> cfg_q == $past(PWDATA[7:0]))
    else $error("write did not land");

  a_wr_ignored: assert property (
    PSEL && PENABLE && PREADY && PWRITE && !(hit && PSTRB[0]) |=> $stable(cfg_q))
    else $error("refused write changed the register");

  a_cfg_steady: assert property (
    !load_now && !wr_fire |=> $stable(cfg_q))
    else $error("register changed without write or load");

  // ==========================================================
  // Coverage
  c_huge_accept: cover property (
    FRM_VALID && cfg_q[`GFP_BIT_HUGE] && FRM_LEN == `GFP_LEN_HUGE ##1 RES_LEN_OK);
  c_cfg_write: cover property (wr_fire ##1 cfg_q[`GFP_BIT_FAIR] == 1'b0);
  c_coll_keep: cover property (
    FRM_VALID && FRM_COLLISIONS >= `GFP_COLL_LIMIT ##1 !RES_COLL_DROP);
  c_bad_addr: cover property (PSLVERR && PREADY);
  c_apb_wait: cover property (PSEL && PENABLE && !PREADY ##1 PREADY);
endmodule // gfp_ctrl

// file: rtl/gfp_frame_policy.sv
// Combinational frame acceptance decisions derived from the policy register
`timescale 1ns/1ps
`include "gfp_params.svh"
module gfp_frame_policy (
  input  wire logic            [7:0] cfg,
  input  wire gfp_pkg::gfp_len_type  frm_len,
  input  wire logic                  frm_tagged,
  input  wire logic                  frm_special_tag,
  input  wire logic                  frm_da_bcast,
  input  wire logic                  frm_da_mcast,
  input  wire logic            [4:0] frm_collisions,
  input  wire logic                  frm_fc_contend,
  output logic                       len_ok,
  output logic                       storm_regulate,
  output logic                       coll_drop,
  output logic                       drop_nonfc,
  output logic                       apply_fc,
  output logic                 [5:0] reserved_bufs
);
  import gfp_pkg::*;

  gfp_size_mode_type size_mode;
  gfp_len_type       max_len;
  logic              use_tag_limit;

  // Huge mode wins; the legal-size bit only counts while huge is off
  assign size_mode = cfg[`GFP_BIT_HUGE]      ? GFP_SIZE_HUGE :
                     cfg[`GFP_BIT_LEGAL_DIS] ? GFP_SIZE_LEGAL_DIS :
                                               GFP_SIZE_NORMAL;
  // Special-tagged frames from the processor port skip the tagged limit
  assign use_tag_limit = frm_tagged && !frm_special_tag;

  always_comb begin
    max_len = `GFP_LEN_UNTAGGED;
    unique case (size_mode)
      GFP_SIZE_HUGE:      max_len = `GFP_LEN_HUGE;
      GFP_SIZE_LEGAL_DIS: max_len = `GFP_LEN_LEGAL_DIS;
      GFP_SIZE_NORMAL:    max_len = use_tag_limit ? `GFP_LEN_TAGGED
                                                  : `GFP_LEN_UNTAGGED;
    endcase
  end

  assign len_ok         = (frm_len <= max_len);
  assign storm_regulate = frm_da_bcast ||
                          (frm_da_mcast && !cfg[`GFP_BIT_MC_EXCL]);
  assign coll_drop      = (frm_collisions >= `GFP_COLL_LIMIT) &&
                          !cfg[`GFP_BIT_NO_COLDROP];
  assign drop_nonfc     = frm_fc_contend && cfg[`GFP_BIT_FAIR];
  assign apply_fc       = frm_fc_contend && !cfg[`GFP_BIT_FAIR];
  assign reserved_bufs  = cfg[`GFP_BIT_PRIO_RSV] ? `GFP_PRIO_BUFS
                                                 : 6'd0;
endmodule // gfp_frame_policy

// file: rtl/gfp_strap_sync.sv
// Two-stage synchroniser for the strap pins with a capture-ready flag
`timescale 1ns/1ps
`include "gfp_params.svh"
module gfp_strap_sync #(
  parameter int NUM_PINS = 2
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic [NUM_PINS-1:0] pins,
  output logic      [NUM_PINS-1:0] pins_sync,
  output logic                     sync_valid
);
  import gfp_pkg::*;

  if (NUM_PINS < 1) begin : g_bad_pins
    $error("gfp_strap_sync needs at least one pin");
  end

  logic [NUM_PINS-1:0] meta_q;
  logic [NUM_PINS-1:0] sync_q;
  logic [1:0]          fill_q;
  logic [1:0]          fill_d;

  assign fill_d     = (fill_q == 2'(`GFP_SYNC_STAGES)) ? fill_q : fill_q + 2'd1;
  assign pins_sync  = sync_q;
  assign sync_valid = (fill_q == 2'(`GFP_SYNC_STAGES));

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      // Pull-down default until the pad level has passed both stages
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= pins[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) fill_q <= 2'd0;
    else       fill_q <= fill_d;
  end
endmodule // gfp_strap_sync

// file: test/gfp_ctrl_tb.sv
// Self-checking testbench for the frame policy control register block
`timescale 1ns/1ps
`include "gfp_params.svh"
module gfp_ctrl_tb;
  import gfp_pkg::*;
  // ==========================================================================
  // Signals
  logic        CORE_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0]  PSTRB;
  logic        COLLISION_POLICY_STRAP_PIN, MAX_SIZE_STRAP_PIN;
  logic        FRM_VALID, FRM_TAGGED, FRM_SPECIAL_TAG, FRM_DA_BCAST, FRM_DA_MCAST;
  logic        FRM_FC_CONTEND, RES_VALID, RES_LEN_OK, RES_STORM_REGULATE;
  logic        RES_COLL_DROP, RES_DROP_NONFC, RES_APPLY_FC;
  gfp_len_type FRM_LEN;
  logic [4:0]  FRM_COLLISIONS;
  logic [5:0]  RESERVED_BUFS;
  int          err_count, samples_checked;
  integer      seed, r;
  logic [7:0]  cfg_m, c;
  logic [9:0]  apb_q[$];
  logic [10:0] res_q[$];
  logic [9:0]  ae;
  logic [10:0] re;
  logic [7:0]  tbl [6] = '{8'hf0, 8'hf4, 8'hf2, 8'hf6, 8'hb9, 8'he8};
  gfp_len_type lens [8] = '{11'd1518, 11'd1519, 11'd1522, 11'd1523,
                            11'd1536, 11'd1537, 11'd1916, 11'd1917};

  gfp_ctrl i_dut (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .COLLISION_POLICY_STRAP_PIN(COLLISION_POLICY_STRAP_PIN),
    .MAX_SIZE_STRAP_PIN(MAX_SIZE_STRAP_PIN), .FRM_VALID(FRM_VALID), .FRM_LEN(FRM_LEN),
    .FRM_TAGGED(FRM_TAGGED), .FRM_SPECIAL_TAG(FRM_SPECIAL_TAG),
    .FRM_DA_BCAST(FRM_DA_BCAST), .FRM_DA_MCAST(FRM_DA_MCAST),
    .FRM_COLLISIONS(FRM_COLLISIONS), .FRM_FC_CONTEND(FRM_FC_CONTEND),
    .RES_VALID(RES_VALID), .RES_LEN_OK(RES_LEN_OK), .RES_STORM_REGULATE(RES_STORM_REGULATE),
    .RES_COLL_DROP(RES_COLL_DROP), .RES_DROP_NONFC(RES_DROP_NONFC),
    .RES_APPLY_FC(RES_APPLY_FC), .RESERVED_BUFS(RESERVED_BUFS)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results;
    if (apb_q.size() != 0 || res_q.size() != 0) err_count++;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic rst(input logic cp, input logic ms, input int w);
    NRST <= 1'b0;
    COLLISION_POLICY_STRAP_PIN <= cp;
    MAX_SIZE_STRAP_PIN <= ms;
    repeat (2) @(posedge CORE_CLK);
    NRST <= 1'b1;
    cfg_m = {4'hf, cp, 1'b0, ms, 1'b0};
    repeat (w) @(posedge CORE_CLK);
  endtask

  // One idle cycle after each transfer keeps every signal to one update per step
  task automatic apb(input bit wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, input logic [7:0] exp, input bit err);
    int n;
    n = 0;
    apb_q.push_back({~wr, err, exp});
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    PSTRB <= s;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1 && n < 50) begin
      @(posedge CORE_CLK);
      n++;
    end
    if (n == 50) err_count++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic qry(input gfp_len_type len, input logic tg, input logic sp, input logic bc,
                     input logic mc, input logic [4:0] co, input logic ct);
    gfp_len_type lim;
    lim = cfg_m[2] ? `GFP_LEN_HUGE : cfg_m[1] ? `GFP_LEN_LEGAL_DIS :
          (tg && !sp) ? `GFP_LEN_TAGGED : `GFP_LEN_UNTAGGED;
    res_q.push_back({len <= lim, bc | (mc & ~cfg_m[6]), (co >= `GFP_COLL_LIMIT) & ~cfg_m[3],
                     ct & cfg_m[4], ct & ~cfg_m[4], cfg_m[0] ? `GFP_PRIO_BUFS : 6'd0});
    FRM_VALID <= 1'b1;
    FRM_LEN <= len;
    FRM_TAGGED <= tg;
    FRM_SPECIAL_TAG <= sp;
    FRM_DA_BCAST <= bc;
    FRM_DA_MCAST <= mc;
    FRM_COLLISIONS <= co;
    FRM_FC_CONTEND <= ct;
    @(posedge CORE_CLK);
  endtask

  // ==========================================================================
  // Output monitor
  always @(posedge CORE_CLK) begin
    if (PREADY === 1'b1) begin
      if (apb_q.size() == 0) begin
        chk(32'h1, 32'h0, "bus answer without request");
      end else begin
        ae = apb_q.pop_front();
        chk(PSLVERR, ae[8], "pslverr");
        if (ae[9]) chk(PRDATA, {24'h0, ae[7:0]}, "prdata");
      end
    end
    if (RES_VALID === 1'b1) begin
      if (res_q.size() == 0) begin
        chk(32'h1, 32'h0, "result without query");
      end else begin
        re = res_q.pop_front();
        chk(RES_LEN_OK, re[10], "length");
        chk(RES_STORM_REGULATE, re[9], "storm");
        chk(RES_COLL_DROP, re[8], "collision drop");
        chk(RES_DROP_NONFC, re[7], "fair drop");
        chk(RES_APPLY_FC, re[6], "flow control");
        chk(RESERVED_BUFS, re[5:0], "buffers");
      end
    end
  end

  // ==========================================================================
  // Stimulus
  initial begin
    seed = 32'hd09f8828;
    err_count = 0;
    samples_checked = 0;
    NRST = 1'b0;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    PSTRB = 4'hf;
    {COLLISION_POLICY_STRAP_PIN, MAX_SIZE_STRAP_PIN} = 2'b00;
    {FRM_VALID, FRM_LEN, FRM_TAGGED, FRM_SPECIAL_TAG, FRM_DA_BCAST} = '0;
    {FRM_DA_MCAST, FRM_COLLISIONS, FRM_FC_CONTEND} = '0;
    rst(1'b1, 1'b0, 4);
    apb(0, `GFP_REG_ADDR, 8'h00, 4'hf, cfg_m, 0);
    // Read at once after this release: the access must wait for the strap load
    rst(1'b0, 1'b1, 0);
    apb(0, `GFP_REG_ADDR, 8'h00, 4'hf, cfg_m, 0);
    apb(1, 12'h008, 8'h00, 4'hf, 8'h00, 1);
    apb(0, 12'h008, 8'h00, 4'hf, 8'h00, 1);
    apb(1, `GFP_REG_ADDR, 8'h0f, 4'he, 8'h00, 0);
    apb(0, `GFP_REG_ADDR, 8'h00, 4'hf, cfg_m, 0);
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      c = (k < 6) ? tbl[k] : (r[7:0] | 8'ha0);
      apb(1, `GFP_REG_ADDR, c, 4'hf, 8'h00, 0);
      cfg_m = c;
      apb(0, `GFP_REG_ADDR, 8'h00, 4'hf, c, 0);
      // Lengths straddle every limit; counts straddle the collision threshold
      for (int j = 0; j < 32; j++) begin
        r = $random(seed);
        qry(lens[j[2:0]], j[3], j[4], r[0], r[1] & ~r[0], 5'd13 + 5'(j[2:0]), r[2]);
      end
      FRM_VALID <= 1'b0;
      @(posedge CORE_CLK);
    end
    repeat (4) @(posedge CORE_CLK);
    results;
  end

  // Whole run is under a thousand cycles; allow twenty times that
  initial begin
    #100000;
    err_count++;
    results;
  end
endmodule // gfp_ctrl_tb
